// ===== rtl/dctm_pkg.sv
package dctm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_DC_TERM_CTRL = 8'h1A;
  localparam logic [7:0] OFS_RSVD_A = 8'h1B;
  localparam logic [7:0] OFS_LOOP_CUR = 8'h1C;
  localparam logic [7:0] OFS_LINE_VOLT = 8'h1D;
  localparam logic [7:0] OFS_RSVD_B = 8'h1E;
  // Field positions of termination control
  localparam int TRIM_LSB = 6;
  localparam int MINI_LSB = 4;
  localparam int CURRENT_LIMIT_ENABLE_BIT = 1;
  localparam int DCR_BIT = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hF3;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] ZERO8 = 8'h00;
  // Fixed settings for variants without adjustment
  localparam logic [1:0] TRIM_FIXED = 2'h2;
  localparam logic [1:0] MINI_FIXED = 2'h0;
  // Pin voltage in mV for each trim code, min loop current in mA
  localparam logic [11:0] TRIM_MV0 = 12'hC1C;
  localparam logic [11:0] TRIM_MV1 = 12'hC80;
  localparam logic [11:0] TRIM_MV2 = 12'hD16;
  localparam logic [11:0] TRIM_MV3 = 12'hDAC;
  localparam logic [4:0] MINI_MA0 = 5'h0A;
  localparam logic [4:0] MINI_MA1 = 5'h0C;
  localparam logic [4:0] MINI_MA2 = 5'h0E;
  localparam logic [4:0] MINI_MA3 = 5'h10;
  localparam logic [6:0] CURRENT_LIMIT_ENABLE_MA = 7'h3C;
  localparam logic [9:0] IMP_LOW_OHM = 10'h032;
  localparam logic [9:0] IMP_HIGH_OHM = 10'h320;
  localparam int CUR_STEP_UA = 1100;
  localparam int VOLT_STEP_MV = 1000;
  typedef enum logic [1:0] {DCTM_NONE, DCTM_CTRL, DCTM_STAT, DCTM_ZERO} dctm_sel_t;
endpackage

// ===== rtl/dctm_term_decode.sv
`timescale 1ns/1ps
// ============================================================
// Termination setting decoder
module dctm_term_decode #(
  parameter bit ADJUSTABLE = 1'b1,
  parameter bit HAS_CURRENT_LIMIT_ENABLE = 1'b1
) (
  input wire logic [7:0] i_ctrl,
  output logic [1:0] o_tip_ring_voltage_trim,
  output logic [11:0] o_dc_termination_pin_mv,
  output logic [1:0] o_min_loop_current_sel,
  output logic [4:0] o_min_loop_current_ma,
  output logic o_current_limit_enable,
  output logic [6:0] o_current_limit_ma,
  output logic o_dc_impedance_select,
  output logic [9:0] o_dc_impedance_ohm
);
  wire [1:0] trim_raw = i_ctrl[dctm_pkg::TRIM_LSB +: 2];
  wire [1:0] mini_raw = i_ctrl[dctm_pkg::MINI_LSB +: 2];
  // Fixed variants ignore the fields
  assign o_tip_ring_voltage_trim = ADJUSTABLE ? trim_raw : dctm_pkg::TRIM_FIXED;
  assign o_min_loop_current_sel = ADJUSTABLE ? mini_raw : dctm_pkg::MINI_FIXED;
  assign o_dc_termination_pin_mv = (o_tip_ring_voltage_trim == 2'h0) ? dctm_pkg::TRIM_MV0 :
                                   (o_tip_ring_voltage_trim == 2'h1) ? dctm_pkg::TRIM_MV1 :
                                   (o_tip_ring_voltage_trim == 2'h2) ? dctm_pkg::TRIM_MV2 :
                                   dctm_pkg::TRIM_MV3;
  assign o_min_loop_current_ma = (o_min_loop_current_sel == 2'h0) ? dctm_pkg::MINI_MA0 :
                                 (o_min_loop_current_sel == 2'h1) ? dctm_pkg::MINI_MA1 :
                                 (o_min_loop_current_sel == 2'h2) ? dctm_pkg::MINI_MA2 :
                                 dctm_pkg::MINI_MA3;
  // Current cap only where the feature exists
  assign o_current_limit_enable = HAS_CURRENT_LIMIT_ENABLE & i_ctrl[dctm_pkg::CURRENT_LIMIT_ENABLE_BIT];
  assign o_current_limit_ma = o_current_limit_enable ? dctm_pkg::CURRENT_LIMIT_ENABLE_MA : 7'h00;
  assign o_dc_impedance_select = i_ctrl[dctm_pkg::DCR_BIT];
  assign o_dc_impedance_ohm = o_dc_impedance_select ? dctm_pkg::IMP_HIGH_OHM : dctm_pkg::IMP_LOW_OHM;
endmodule

// ===== rtl/dctm_line_monitor.sv
`timescale 1ns/1ps
// ============================================================
// Measurement capture for loop current and line voltage
module dctm_line_monitor (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_meas_valid,
  input wire logic [7:0] i_loop_current,
  input wire logic [7:0] i_line_voltage,
  output logic [7:0] o_loop_current_value,
  output logic [7:0] o_line_voltage_value,
  output logic o_polarity_reversal,
  output logic o_loop_current_low,
  output logic o_line_absent
);
  logic [7:0] cur_q;
  logic [7:0] volt_q;
  logic rev_q;
  // Samples taken whatever the hook state; bus writes never reach here
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cur_q <= dctm_pkg::STAT_RST;
      volt_q <= dctm_pkg::STAT_RST;
      rev_q <= 1'b0;
    end else begin
      rev_q <= 1'b0;
      if (i_meas_valid) begin
        cur_q <= i_loop_current;
        volt_q <= i_line_voltage;
        rev_q <= (i_line_voltage[7] != volt_q[7]);
      end
    end
  end
  assign o_loop_current_value = cur_q;
  assign o_line_voltage_value = volt_q;
  assign o_polarity_reversal = rev_q;
  assign o_loop_current_low = (cur_q == dctm_pkg::ZERO8);
  assign o_line_absent = (volt_q == dctm_pkg::ZERO8);
endmodule

// ===== rtl/dctm_regs.sv
`timescale 1ns/1ps
// ============================================================
// Termination control and line monitor register slice
module dctm_regs #(
  parameter bit ADJUSTABLE = 1'b1,
  parameter bit HAS_CURRENT_LIMIT_ENABLE = 1'b1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_meas_valid,
  input wire logic [7:0] i_loop_current,
  input wire logic [7:0] i_line_voltage,
  output logic [1:0] o_tip_ring_voltage_trim,
  output logic [11:0] o_dc_termination_pin_mv,
  output logic [1:0] o_min_loop_current_sel,
  output logic [4:0] o_min_loop_current_ma,
  output logic o_current_limit_enable,
  output logic [6:0] o_current_limit_ma,
  output logic o_dc_impedance_select,
  output logic [9:0] o_dc_impedance_ohm,
  output logic o_polarity_reversal,
  output logic o_loop_current_low,
  output logic o_line_absent
);
  // ============================================================
  // Reset synchroniser
  logic rst_s1_q;
  logic rst_s2_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // ============================================================
  // Address decode
  wire hit_ctrl = (i_addr == dctm_pkg::OFS_DC_TERM_CTRL);
  wire hit_cur = (i_addr == dctm_pkg::OFS_LOOP_CUR);
  wire hit_volt = (i_addr == dctm_pkg::OFS_LINE_VOLT);
  wire [7:0] loop_cur;
  wire [7:0] line_volt;

  // Only the control register accepts writes; reserved bits 3:2 are not stored
  logic [7:0] ctrl_q;
  wire [7:0] ctrl_d = (i_wr && hit_ctrl) ? (i_wdata & dctm_pkg::CTRL_WMASK) : ctrl_q;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= dctm_pkg::CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Read mux; reserved and unmapped locations return zero
  wire [7:0] rd_mux = hit_ctrl ? ctrl_q :
                      hit_cur ? loop_cur :
                      hit_volt ? line_volt : dctm_pkg::ZERO8;
  logic [7:0] rdata_q;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= dctm_pkg::ZERO8;
    end else begin
      rdata_q <= i_rd ? rd_mux : dctm_pkg::ZERO8;
    end
  end
  assign o_rdata = rdata_q;

  // ============================================================
  // Submodules
  dctm_term_decode #(.ADJUSTABLE(ADJUSTABLE), .HAS_CURRENT_LIMIT_ENABLE(HAS_CURRENT_LIMIT_ENABLE)) u_dec (
    .i_ctrl(ctrl_q),
    .o_tip_ring_voltage_trim(o_tip_ring_voltage_trim),
    .o_dc_termination_pin_mv(o_dc_termination_pin_mv),
    .o_min_loop_current_sel(o_min_loop_current_sel),
    .o_min_loop_current_ma(o_min_loop_current_ma),
    .o_current_limit_enable(o_current_limit_enable),
    .o_current_limit_ma(o_current_limit_ma),
    .o_dc_impedance_select(o_dc_impedance_select),
    .o_dc_impedance_ohm(o_dc_impedance_ohm)
  );
  dctm_line_monitor u_mon (
    .i_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_meas_valid(i_meas_valid),
    .i_loop_current(i_loop_current),
    .i_line_voltage(i_line_voltage),
    .o_loop_current_value(loop_cur),
    .o_line_voltage_value(line_volt),
    .o_polarity_reversal(o_polarity_reversal),
    .o_loop_current_low(o_loop_current_low),
    .o_line_absent(o_line_absent)
  );
endmodule

// ===== tb/dctm_regs_props.sv
`timescale 1ns/1ps
// ==========
// Port checker for the register slice
module dctm_regs_chk (
  input wire logic i_ref_clk, i_rst_n, i_wr, i_rd, i_meas_valid, o_current_limit_enable, o_dc_impedance_select,
  input wire logic o_polarity_reversal, o_loop_current_low, o_line_absent,
  input wire logic [7:0] i_addr, i_wdata, o_rdata, i_loop_current, i_line_voltage,
  input wire logic [1:0] o_tip_ring_voltage_trim, o_min_loop_current_sel,
  input wire logic [11:0] o_dc_termination_pin_mv,
  input wire logic [4:0] o_min_loop_current_ma,
  input wire logic [6:0] o_current_limit_ma,
  input wire logic [9:0] o_dc_impedance_ohm
);
  localparam logic [11:0] MV [4] = '{12'hC1C, 12'hC80, 12'hD16, 12'hDAC};
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // Decoded values follow their codes; writes and samples land one cycle later
  chk_trim_pin: assert property (o_dc_termination_pin_mv == MV[o_tip_ring_voltage_trim])
    else $error("pin voltage wrong");
  chk_mini_ma: assert property (o_min_loop_current_ma == 5'h0A + {2'h0, o_min_loop_current_sel, 1'b0})
    else $error("min current wrong");
  chk_limit_ma: assert property (o_current_limit_ma == (o_current_limit_enable ? 7'h3C : 7'h00))
    else $error("limit wrong");
  chk_imp_ohm: assert property (o_dc_impedance_ohm == (o_dc_impedance_select ? 10'h320 : 10'h032))
    else $error("impedance wrong");
  chk_ctrl_write: assert property (i_wr && i_addr == 8'h1A |=> o_dc_impedance_select == $past(i_wdata[0]))
    else $error("write not applied");
  chk_cur_read: assert property (i_meas_valid ##1 (i_rd && i_addr == 8'h1C) |=>
    o_rdata == $past(i_loop_current, 2)) else $error("current read wrong");
  chk_cur_low: assert property (i_meas_valid |=> o_loop_current_low == ($past(i_loop_current) == 8'h00))
    else $error("low flag wrong");
  chk_line_gone: assert property (i_meas_valid |=> o_line_absent == ($past(i_line_voltage) == 8'h00))
    else $error("absent flag wrong");
  chk_rev_cause: assert property (o_polarity_reversal |-> $past(i_meas_valid))
    else $error("stray reversal");
  cover property (i_wr && i_addr == 8'h1A);
  cover property (o_polarity_reversal);
  cover property (i_meas_valid ##1 i_rd);
endmodule
bind dctm_regs dctm_regs_chk u_chk (.*);

// ===== tb/dctm_host_model.sv
`timescale 1ns/1ps
// ==========
// Host relay driving the register port
module dctm_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0
);
  // One-cycle write; reserved register 1B skipped, reserved bits kept clear
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a != 8'h1B) begin
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= a;
      o_wdata <= (a == 8'h1A) ? (d & 8'hF3) : d;
      @(posedge i_clk);
      o_wr <= 1'b0;
    end
  endtask
  // One-cycle read; data taken in the cycle after
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(negedge i_clk);
    d = i_rdata;
  endtask
endmodule

// ===== tb/dctm_regs_tb.sv
`timescale 1ns/1ps
// ==========
// Register slice bench
module dctm_regs_tb;
  logic [19:0] rows [4] = '{{8'h00, 12'hC1C}, {8'h53, 12'hC80}, {8'hA2, 12'hD16}, {8'hF1, 12'hDAC}};
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_wr, i_rd, i_meas_valid = 1'b0, o_current_limit_enable;
  logic o_dc_impedance_select, o_polarity_reversal, o_loop_current_low, o_line_absent;
  logic [7:0] i_addr, i_wdata, o_rdata, i_loop_current = 8'h00, i_line_voltage = 8'h00, d;
  logic [1:0] o_tip_ring_voltage_trim, o_min_loop_current_sel;
  logic [11:0] o_dc_termination_pin_mv;
  logic [4:0] o_min_loop_current_ma;
  logic [6:0] o_current_limit_ma;
  logic [9:0] o_dc_impedance_ohm;
  int failures = 0;
  int checks = 0;
  dctm_regs uut (.*);
  dctm_host_model host (.i_clk(i_ref_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd));
  // Compare and count
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Verdict
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One measurement sample, then the reversal pulse it should give
  task automatic meas(input logic [7:0] c, input logic [7:0] v, input logic r);
    @(posedge i_ref_clk);
    i_meas_valid <= 1'b1;
    i_loop_current <= c;
    i_line_voltage <= v;
    @(posedge i_ref_clk);
    i_meas_valid <= 1'b0;
    @(negedge i_ref_clk);
    chk("reversal", {11'h000, o_polarity_reversal}, {11'h000, r});
  endtask
  // Clock
  initial forever #12.5 i_ref_clk = ~i_ref_clk;
  // Watchdog
  initial begin
    #50000 failures++;
    end_of_test();
  end
  // Reset, settings table, then monitor and refusal cases
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    host.rd(8'h1A, d);
    chk("ctrl_rst", {4'h0, d}, 12'h000);
    foreach (rows[i]) begin
      host.wr(8'h1A, rows[i][19:12]);
      host.rd(8'h1A, d);
      chk("ctrl_rd", {4'h0, d}, {4'h0, rows[i][19:12]});
      chk("pin_mv", o_dc_termination_pin_mv, rows[i][11:0]);
    end
    meas(8'h2D, 8'hD0, 1'b1);
    host.wr(8'h1C, 8'hFF);
    host.wr(8'h1D, 8'h00);
    host.rd(8'h1C, d);
    chk("loop_cur", {4'h0, d}, 12'h02D);
    host.rd(8'h1D, d);
    chk("line_volt", {4'h0, d}, 12'h0D0);
    meas(8'h01, 8'h30, 1'b1);
    meas(8'h02, 8'h10, 1'b0);
    // Sample followed at once by a read: the new value must already show
    @(posedge i_ref_clk);
    i_meas_valid <= 1'b1;
    i_loop_current <= 8'h44;
    fork
      host.rd(8'h1C, d);
      begin
        @(posedge i_ref_clk);
        i_meas_valid <= 1'b0;
      end
    join
    chk("cur_fresh", {4'h0, d}, 12'h044);
    meas(8'h00, 8'h00, 1'b0);
    chk("low_absent", {10'h000, o_loop_current_low, o_line_absent}, 12'h003);
    host.rd(8'h55, d);
    chk("unmapped", {4'h0, d}, 12'h000);
    end_of_test();
  end
endmodule
